// *** verilog/stm_defines.svh ***
// Constants of the servo trip monitor: offsets, fields, reset values, codes and timing.
`ifndef STM_DEFINES_SVH
`define STM_DEFINES_SVH
// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define STM_OFF_CTRL 12'h000
`define STM_OFF_POS_LIM 12'h004
`define STM_OFF_SPD_LIM 12'h008
`define STM_OFF_OVS 12'h00C
`define STM_OFF_WIN_LO 12'h010
`define STM_OFF_WIN_HI 12'h014
`define STM_OFF_SETTLE 12'h018
`define STM_OFF_INPOS 12'h01C
`define STM_OFF_LINK_TMO 12'h020
`define STM_OFF_NEST_MAX 12'h024
`define STM_OFF_STATUS 12'h028
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define STM_CTRL_LINK_A 0
`define STM_CTRL_LINK_B 1
`define STM_CTRL_SRC_LO 2
`define STM_CTRL_SRC_HI 3
`define STM_CTRL_REMAP 4
`define STM_CTRL_V400 5
`define STM_OVS_RATIO_HI 7
`define STM_OVS_MAX_LO 16
// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define STM_RST_CTRL 6'h00
`define STM_RST_POS_LIM 32'h0001_0000
`define STM_RST_SPD_LIM 16'h0400
`define STM_RST_RATIO 8'h78
`define STM_RST_MAX_SPD 16'h1770
`define STM_RST_WIN_LO 32'h8000_0000
`define STM_RST_WIN_HI 32'h7FFF_FFFF
`define STM_RST_SETTLE 32'h0001_E848
`define STM_RST_INPOS 32'h0000_0040
`define STM_RST_LINK_TMO 32'h0001_E848
`define STM_RST_NEST_MAX 4'h8
`define STM_RST_POS_VALID 1'b1
// ----------------------------------------------------------------------------
// Display codes
// ----------------------------------------------------------------------------
`define STM_CODE_NONE 8'h00
`define STM_CODE_E14 8'h0E
`define STM_CODE_E31 8'h1F
`define STM_CODE_E44 8'h2C
`define STM_CODE_E45 8'h2D
`define STM_CODE_E46 8'h2E
`define STM_CODE_E60 8'h3C
`define STM_CODE_E83 8'h53
`define STM_CODE_E84 8'h54
`define STM_CODE_E85 8'h55
`define STM_CODE_E88 8'h58
`define STM_CODE_E89 8'h59
`define STM_CODE_E90 8'h5A
`define STM_CODE_E91 8'h5B
`define STM_CODE_E92 8'h5C
`define STM_CODE_E93 8'h5D
`define STM_CODE_E97 8'h61
`define STM_CODE_E98 8'h62
`define STM_CODE_E99 8'h63
`define STM_CODE_UV 8'hFE
`define STM_CODE_ERR 8'hEE
// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define STM_CLK_HZ 64'd125000000
`define STM_ENCODER_CLEAR_IN_HOLD_S 64'd4
`define STM_ENCODER_CLEAR_IN_HOLD_CYC (`STM_ENCODER_CLEAR_IN_HOLD_S * `STM_CLK_HZ)
`define STM_SPD_SCALE 32'h0000_0064
`endif

// *** verilog/stm_pkg.sv ***
// Types of the servo trip monitor.
package stm_pkg;
    typedef enum logic [2:0] {
        STM_OK = 3'b001,
        STM_TRIPPED = 3'b010,
        STM_LOCKED = 3'b100
    } stm_trip_st_t;

    typedef struct packed {
        stm_trip_st_t st;
        logic [7:0] code;
        logic [7:0] disp;
        logic alarm;
        logic trip;
        logic pos_valid;
        logic err_tune;
        logic encoder_clear_in_done;
        logic [31:0] encoder_clear_in_cnt;
        logic rst_prev;
        logic gf_pend;
        logic [31:0] link_cnt;
        logic [31:0] settle_cnt;
        logic settle_run;
        logic tgt_prev;
        logic [5:0] ctrl;
        logic [31:0] pos_lim;
        logic [15:0] spd_lim;
        logic [7:0] ratio;
        logic [15:0] max_spd;
        logic [31:0] win_lo;
        logic [31:0] win_hi;
        logic [31:0] settle_lim;
        logic [31:0] inpos;
        logic [31:0] link_tmo;
        logic [3:0] nest_max;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } stm_state_t;
endpackage

// *** verilog/stm_pin_sync.sv ***
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/100ps
module stm_pin_sync (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic pin_i,
    output logic level_o
);
    logic [2:0] ff_q;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ff_q <= 3'h0;
            level_o <= 1'b0;
        end else begin
            ff_q <= {ff_q[1:0], pin_i};
            if (ff_q[1] == ff_q[2]) begin
                level_o <= ff_q[2];
            end
        end
    end
endmodule // stm_pin_sync

// *** verilog/stm_absdiff.sv ***
// Magnitude of the difference of two signed values.
`timescale 1ns/100ps
module stm_absdiff #(
    parameter int W = 32
) (
    input wire logic signed [W-1:0] a_i,
    input wire logic signed [W-1:0] b_i,
    output logic [W:0] mag_o
);
    logic signed [W:0] diff;
    always_comb begin
        diff = {a_i[W-1], a_i} - {b_i[W-1], b_i};
        mag_o = diff[W] ? -diff : diff;
    end
endmodule // stm_absdiff

// *** verilog/stm_trip_monitor.sv ***
// Trip detection, latching, alarm gating and clear sequencing with an APB register file.
//
// Notes on behaviour
// - Nesting deeper than limit raises E44.
// - Program execution failure raises E45.
// - Servo-on from wrong source raises E46.
// - Missing master requests raise E60.
// - Position error over limit raises E83.
// - Speed error over limit raises E84.
// - Speed over max times ratio percent raises E85.
// - Position outside travel window raises E88.
// - Slow settling after target raises E89.
// - Battery failure E90; clear-hold, then reset.
// - Low battery warns E91; position stays valid.
// - Counter overflow E92; clear-hold, then reset.
// - Encoder fault E93; clear-hold, then reset.
// - Encoder link faults raise E97 or E98.
// - Encoder count inconsistency raises E99.
// - Low control supply at servo-off indicates.
// - Failed auto-tuning shows Err.
// - Those two indications never drive alarm.
// - Program trips alarm only when remapped.
// - Power module trip cleared by reset only when V400 is set and the fault is gone.
// - Variant reset clear arms E14 at servo-on.
`timescale 1ns/100ps
`include "stm_defines.svh"
module stm_trip_monitor #(
    parameter logic [31:0] ENCODER_CLEAR_IN_HOLD_CYC = 32'(`STM_ENCODER_CLEAR_IN_HOLD_CYC)
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic encoder_clear_in_i,
    input wire logic trip_reset_in_i,
    input wire logic servo_on_cmd_i,
    input wire logic [1:0] servo_on_src_i,
    input wire logic servo_on_state_i,
    input wire logic prog_run_i,
    input wire logic [3:0] nest_depth_i,
    input wire logic prog_exec_fail_i,
    input wire logic master_req_i,
    input wire logic signed [31:0] pos_cmd_i,
    input wire logic signed [31:0] pos_det_i,
    input wire logic signed [15:0] spd_cmd_i,
    input wire logic signed [15:0] spd_det_i,
    input wire logic pos_cmd_done_i,
    input wire logic enc_batt_fail_i,
    input wire logic enc_batt_low_i,
    input wire logic enc_cnt_ovf_i,
    input wire logic enc_fault_i,
    input wire logic enc_comm_err1_i,
    input wire logic enc_comm_err2_i,
    input wire logic enc_count_err_i,
    input wire logic ctrl_uv_i,
    input wire logic autotune_fail_i,
    input wire logic power_module_fault_i,
    output logic alarm_out_o,
    output logic trip_active_o,
    output logic [7:0] display_code_o,
    output logic abs_pos_valid_o
);
    stm_pkg::stm_state_t s_q;
    stm_pkg::stm_state_t s_d;
    logic encoder_clear_in_lvl;
    logic trip_reset_lvl;
    logic [32:0] pos_mag;
    logic [16:0] spd_mag;
    logic [16:0] spd_abs;
    logic [31:0] spd_scaled;
    logic [31:0] spd_max_scaled;
    logic rst_rise;
    logic det;
    logic [7:0] det_code;
    logic clear_ok;
    logic abs_code;
    logic prog_code;
    logic link_on;
    logic wr_go;
    logic rd_go;

    // ------------------------------------------------------------------------
    // Pin synchronisers and magnitude helpers
    // ------------------------------------------------------------------------
    stm_pin_sync u_sync_encoder_clear_in (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .pin_i(encoder_clear_in_i),
        .level_o(encoder_clear_in_lvl)
    );
    stm_pin_sync u_sync_rst (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .pin_i(trip_reset_in_i),
        .level_o(trip_reset_lvl)
    );
    stm_absdiff #(.W(32)) u_pos_err (
        .a_i(pos_cmd_i),
        .b_i(pos_det_i),
        .mag_o(pos_mag)
    );
    stm_absdiff #(.W(16)) u_spd_err (
        .a_i(spd_cmd_i),
        .b_i(spd_det_i),
        .mag_o(spd_mag)
    );
    stm_absdiff #(.W(16)) u_spd_abs (
        .a_i(spd_det_i),
        .b_i(16'h0000),
        .mag_o(spd_abs)
    );

    // ------------------------------------------------------------------------
    // Fault detection in priority order
    // ------------------------------------------------------------------------
    always_comb begin
        spd_scaled = 32'(spd_abs) * `STM_SPD_SCALE;
        spd_max_scaled = 32'(s_q.max_spd) * 32'(s_q.ratio);
        link_on = s_q.ctrl[`STM_CTRL_LINK_A] & s_q.ctrl[`STM_CTRL_LINK_B];
        det = 1'b1;
        det_code = `STM_CODE_NONE;
        if (s_q.gf_pend && servo_on_cmd_i) begin
            det_code = `STM_CODE_E14;
        end else if (enc_count_err_i) begin
            det_code = `STM_CODE_E99;
        end else if (enc_comm_err2_i) begin
            det_code = `STM_CODE_E98;
        end else if (enc_comm_err1_i) begin
            det_code = `STM_CODE_E97;
        end else if (enc_fault_i) begin
            det_code = `STM_CODE_E93;
        end else if (enc_cnt_ovf_i) begin
            det_code = `STM_CODE_E92;
        end else if (enc_batt_fail_i) begin
            det_code = `STM_CODE_E90;
        end else if (spd_scaled > spd_max_scaled) begin
            det_code = `STM_CODE_E85;
        end else if (pos_mag > {1'b0, s_q.pos_lim}) begin
            det_code = `STM_CODE_E83;
        end else if (spd_mag > {1'b0, s_q.spd_lim}) begin
            det_code = `STM_CODE_E84;
        end else if ($signed(pos_det_i) < $signed(s_q.win_lo)
                     || $signed(pos_det_i) > $signed(s_q.win_hi)) begin
            det_code = `STM_CODE_E88;
        end else if (s_q.settle_run && s_q.settle_cnt > s_q.settle_lim) begin
            det_code = `STM_CODE_E89;
        end else if (link_on && s_q.link_cnt > s_q.link_tmo) begin
            det_code = `STM_CODE_E60;
        end else if (servo_on_cmd_i
                     && servo_on_src_i != s_q.ctrl[`STM_CTRL_SRC_HI:`STM_CTRL_SRC_LO]) begin
            det_code = `STM_CODE_E46;
        end else if (prog_run_i && prog_exec_fail_i) begin
            det_code = `STM_CODE_E45;
        end else if (prog_run_i && nest_depth_i > s_q.nest_max) begin
            det_code = `STM_CODE_E44;
        end else begin
            det = 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Next state: counters, trip latch, clear sequences, registers
    // ------------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        rst_rise = trip_reset_lvl & ~s_q.rst_prev;
        abs_code = (s_q.code == `STM_CODE_E90) || (s_q.code == `STM_CODE_E92)
                   || (s_q.code == `STM_CODE_E93);
        s_d.rst_prev = trip_reset_lvl;
        s_d.tgt_prev = pos_cmd_done_i;
        if (!encoder_clear_in_lvl) begin
            s_d.encoder_clear_in_cnt = 32'h0000_0000;
        end else if (s_q.encoder_clear_in_cnt >= ENCODER_CLEAR_IN_HOLD_CYC - 32'h0000_0001) begin
            s_d.encoder_clear_in_done = 1'b1;
        end else begin
            s_d.encoder_clear_in_cnt = s_q.encoder_clear_in_cnt + 32'h0000_0001;
        end
        if (!link_on || master_req_i) begin
            s_d.link_cnt = 32'h0000_0000;
        end else if (s_q.link_cnt != 32'hFFFF_FFFF) begin
            s_d.link_cnt = s_q.link_cnt + 32'h0000_0001;
        end
        if (pos_cmd_done_i && !s_q.tgt_prev) begin
            s_d.settle_run = 1'b1;
            s_d.settle_cnt = 32'h0000_0000;
        end else if (s_q.settle_run) begin
            if (pos_mag <= {1'b0, s_q.inpos}) begin
                s_d.settle_run = 1'b0;
            end else if (s_q.settle_cnt != 32'hFFFF_FFFF) begin
                s_d.settle_cnt = s_q.settle_cnt + 32'h0000_0001;
            end
        end
        clear_ok = 1'b0;
        case (s_q.st)
            stm_pkg::STM_TRIPPED: begin
                if (rst_rise) begin
                    if (!abs_code) begin
                        clear_ok = 1'b1;
                    end else if (s_q.encoder_clear_in_done
                                 && !(s_q.code == `STM_CODE_E90 && enc_batt_fail_i)) begin
                        clear_ok = 1'b1;
                    end
                end
            end
            stm_pkg::STM_LOCKED: begin
                if (rst_rise && s_q.ctrl[`STM_CTRL_V400] && !power_module_fault_i) begin
                    clear_ok = 1'b1;
                    s_d.gf_pend = 1'b1;
                end
            end
            default: begin
                clear_ok = 1'b0;
            end
        endcase
        if (clear_ok) begin
            s_d.st = stm_pkg::STM_OK;
            s_d.code = `STM_CODE_NONE;
            if (abs_code) begin
                s_d.encoder_clear_in_done = encoder_clear_in_lvl && s_q.encoder_clear_in_cnt >= ENCODER_CLEAR_IN_HOLD_CYC - 32'h0000_0001;
            end
        end
        if (power_module_fault_i && s_q.st != stm_pkg::STM_LOCKED) begin
            s_d.st = stm_pkg::STM_LOCKED;
            s_d.code = `STM_CODE_E31;
        end else if (s_d.st == stm_pkg::STM_OK && det) begin
            s_d.st = stm_pkg::STM_TRIPPED;
            s_d.code = det_code;
            if (det_code == `STM_CODE_E14) begin
                s_d.gf_pend = 1'b0;
            end
        end
        if (autotune_fail_i) begin
            s_d.err_tune = 1'b1;
        end else if (rst_rise) begin
            s_d.err_tune = 1'b0;
        end
        prog_code = (s_d.code == `STM_CODE_E44) || (s_d.code == `STM_CODE_E45);
        s_d.alarm = (s_d.st != stm_pkg::STM_OK)
                    && (!prog_code || s_d.ctrl[`STM_CTRL_REMAP]);
        s_d.trip = (s_d.st != stm_pkg::STM_OK);
        s_d.pos_valid = (s_d.code != `STM_CODE_E90);
        if (s_d.st != stm_pkg::STM_OK) begin
            s_d.disp = s_d.code;
        end else if (s_d.err_tune) begin
            s_d.disp = `STM_CODE_ERR;
        end else if (ctrl_uv_i && !servo_on_state_i) begin
            s_d.disp = `STM_CODE_UV;
        end else if (enc_batt_low_i) begin
            s_d.disp = `STM_CODE_E91;
        end else begin
            s_d.disp = `STM_CODE_NONE;
        end
        // APB slave: one wait state, write lands on the completing edge.
        wr_go = psel_i & penable_i & pwrite_i & s_q.pready;
        rd_go = psel_i & penable_i & ~s_q.pready;
        s_d.pready = rd_go;
        s_d.pslverr = 1'b0;
        s_d.prdata = 32'h0000_0000;
        if (rd_go) begin
            if (paddr_i == `STM_OFF_CTRL) begin
                s_d.prdata = {26'h000_0000, s_q.ctrl};
            end else if (paddr_i == `STM_OFF_POS_LIM) begin
                s_d.prdata = s_q.pos_lim;
            end else if (paddr_i == `STM_OFF_SPD_LIM) begin
                s_d.prdata = {16'h0000, s_q.spd_lim};
            end else if (paddr_i == `STM_OFF_OVS) begin
                s_d.prdata = {s_q.max_spd, 8'h00, s_q.ratio};
            end else if (paddr_i == `STM_OFF_WIN_LO) begin
                s_d.prdata = s_q.win_lo;
            end else if (paddr_i == `STM_OFF_WIN_HI) begin
                s_d.prdata = s_q.win_hi;
            end else if (paddr_i == `STM_OFF_SETTLE) begin
                s_d.prdata = s_q.settle_lim;
            end else if (paddr_i == `STM_OFF_INPOS) begin
                s_d.prdata = s_q.inpos;
            end else if (paddr_i == `STM_OFF_LINK_TMO) begin
                s_d.prdata = s_q.link_tmo;
            end else if (paddr_i == `STM_OFF_NEST_MAX) begin
                s_d.prdata = {28'h000_0000, s_q.nest_max};
            end else if (paddr_i == `STM_OFF_STATUS) begin
                s_d.prdata = {16'h0000, 1'b0, ~enc_batt_fail_i, s_q.gf_pend, s_q.encoder_clear_in_done,
                              s_q.err_tune, s_q.st, s_q.disp};
                s_d.pslverr = pwrite_i;
            end else begin
                s_d.pslverr = 1'b1;
            end
        end
        if (wr_go && !s_q.pslverr) begin
            if (paddr_i == `STM_OFF_CTRL) begin
                s_d.ctrl = pwdata_i[5:0];
            end else if (paddr_i == `STM_OFF_POS_LIM) begin
                s_d.pos_lim = pwdata_i;
            end else if (paddr_i == `STM_OFF_SPD_LIM) begin
                s_d.spd_lim = pwdata_i[15:0];
            end else if (paddr_i == `STM_OFF_OVS) begin
                s_d.ratio = pwdata_i[`STM_OVS_RATIO_HI:0];
                s_d.max_spd = pwdata_i[31:`STM_OVS_MAX_LO];
            end else if (paddr_i == `STM_OFF_WIN_LO) begin
                s_d.win_lo = pwdata_i;
            end else if (paddr_i == `STM_OFF_WIN_HI) begin
                s_d.win_hi = pwdata_i;
            end else if (paddr_i == `STM_OFF_SETTLE) begin
                s_d.settle_lim = pwdata_i;
            end else if (paddr_i == `STM_OFF_INPOS) begin
                s_d.inpos = pwdata_i;
            end else if (paddr_i == `STM_OFF_LINK_TMO) begin
                s_d.link_tmo = pwdata_i;
            end else if (paddr_i == `STM_OFF_NEST_MAX) begin
                s_d.nest_max = pwdata_i[3:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_q <= '0;
            s_q.st <= stm_pkg::STM_OK;
            s_q.ctrl <= `STM_RST_CTRL;
            s_q.pos_lim <= `STM_RST_POS_LIM;
            s_q.spd_lim <= `STM_RST_SPD_LIM;
            s_q.ratio <= `STM_RST_RATIO;
            s_q.max_spd <= `STM_RST_MAX_SPD;
            s_q.win_lo <= `STM_RST_WIN_LO;
            s_q.win_hi <= `STM_RST_WIN_HI;
            s_q.settle_lim <= `STM_RST_SETTLE;
            s_q.inpos <= `STM_RST_INPOS;
            s_q.link_tmo <= `STM_RST_LINK_TMO;
            s_q.nest_max <= `STM_RST_NEST_MAX;
            s_q.pos_valid <= `STM_RST_POS_VALID;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata_o = s_q.prdata;
    assign pready_o = s_q.pready;
    assign pslverr_o = s_q.pslverr;
    assign alarm_out_o = s_q.alarm;
    assign trip_active_o = s_q.trip;
    assign display_code_o = s_q.disp;
    assign abs_pos_valid_o = s_q.pos_valid;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    a_pos_err_trip: assert property (@(posedge clk_i) disable iff (!resetn_i)
        s_q.st == stm_pkg::STM_OK && pos_mag > {1'b0, s_q.pos_lim} |=> trip_active_o)
        else $error("position error over limit did not trip");
    a_link_timeout: assert property (@(posedge clk_i) disable iff (!resetn_i)
        s_q.st == stm_pkg::STM_OK && link_on && s_q.link_cnt > s_q.link_tmo
        |=> trip_active_o)
        else $error("missing master requests did not trip");
    a_power_locked: assert property (@(posedge clk_i) disable iff (!resetn_i)
        s_q.st == stm_pkg::STM_LOCKED && !s_q.ctrl[`STM_CTRL_V400]
        |=> s_q.st == stm_pkg::STM_LOCKED && s_q.code == `STM_CODE_E31)
        else $error("power module trip left its locked state");
    a_gf_next_son: assert property (@(posedge clk_i) disable iff (!resetn_i)
        s_q.st == stm_pkg::STM_OK && s_q.gf_pend && servo_on_cmd_i && !power_module_fault_i
        |=> s_q.code == `STM_CODE_E14 && alarm_out_o)
        else $error("ground fault not raised at servo-on");
    a_clear_restart: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !encoder_clear_in_lvl |=> s_q.encoder_clear_in_cnt == 32'h0000_0000)
        else $error("clear-hold count not restarted");
    a_abs_clear_gate: assert property (@(posedge clk_i) disable iff (!resetn_i)
        s_q.st == stm_pkg::STM_TRIPPED && abs_code && !s_q.encoder_clear_in_done |=> trip_active_o)
        else $error("encoder trip cleared without clear-hold");
    a_trip_latched: assert property (@(posedge clk_i) disable iff (!resetn_i)
        s_q.st == stm_pkg::STM_TRIPPED && !rst_rise && !power_module_fault_i
        |=> $stable(s_q.code) && trip_active_o)
        else $error("latched trip code changed without clear");
    a_idle_no_alarm: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !trip_active_o |-> !alarm_out_o)
        else $error("alarm driven without a latched trip");
    a_prog_alarm: assert property (@(posedge clk_i) disable iff (!resetn_i)
        trip_active_o && s_q.code == `STM_CODE_E45 |-> alarm_out_o == s_q.ctrl[`STM_CTRL_REMAP])
        else $error("program trip alarm not gated by remap");
    a_apb_answer: assert property (@(posedge clk_i) disable iff (!resetn_i)
        psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o)
        else $error("register bus answer not one cycle after access");
endmodule // stm_trip_monitor

// *** verification/stm_far_model.sv ***
// Far side: option master sending requests, and encoder fault lines.
`timescale 1ns/100ps
module stm_far_model (
    input wire logic clk_i,
    input wire logic quiet_i,
    input wire logic [5:0] fault_i,
    output logic master_req_o,
    output logic [5:0] enc_o
);
    logic [3:0] cnt_q = 4'h0;
    always_ff @(posedge clk_i) begin
        cnt_q <= cnt_q + 4'h1;
        master_req_o <= !quiet_i && cnt_q == 4'h0;
    end
    assign enc_o = fault_i;
endmodule // stm_far_model

// *** verification/stm_trip_monitor_bench.sv ***
// Self-checking bench of the trip monitor.
`timescale 1ns/100ps
module stm_trip_monitor_bench;
    logic clk_i = 0, resetn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, quiet = 0;
    logic encoder_clear_in_i = 0, trip_reset_in_i = 0, pmf = 0, req, pready_o, pslverr_o;
    logic alarm_out_o, abs_pos_valid_o, trip_active_o;
    logic [7:0] display_code_o;
    logic [2:0] ind = '0;
    logic [7:0] dc [3] = '{8'h5B, 8'hFE, 8'hEE};
    logic [11:0] paddr_i = '0;
    logic [31:0] pwdata_i = '0, prdata_o, rng = 32'hE31A_C780;
    logic signed [31:0] pos_cmd_i = '0, pos_det_i = '0;
    logic signed [15:0] spd = '0;
    logic [3:0] nest_depth_i = '0;
    logic [7:0] flt = '0;
    logic [5:0] enc;
    logic [7:0] codes [8] = '{8'h2D, 8'h2E, 8'h61, 8'h62, 8'h63, 8'h5A, 8'h5C, 8'h5D};
    logic [33:0] exp_q [$];
    int err_count = 0, n_compared = 0;
    stm_far_model far (.clk_i, .quiet_i(quiet), .fault_i(flt[7:2]), .master_req_o(req),
        .enc_o(enc));
    stm_trip_monitor #(.ENCODER_CLEAR_IN_HOLD_CYC(32'd20)) DUT (.clk_i, .resetn_i, .psel_i, .penable_i,
        .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .encoder_clear_in_i,
        .trip_reset_in_i, .servo_on_cmd_i(flt[1]), .servo_on_src_i(2'b01),
        .servo_on_state_i(1'b0), .prog_run_i(1'b1), .nest_depth_i, .prog_exec_fail_i(flt[0]),
        .master_req_i(req), .pos_cmd_i, .pos_det_i, .spd_cmd_i(spd), .spd_det_i(spd),
        .pos_cmd_done_i(1'b0), .enc_batt_fail_i(enc[3]), .enc_batt_low_i(ind[0]),
        .enc_cnt_ovf_i(enc[4]), .enc_fault_i(enc[5]), .enc_comm_err1_i(enc[0]),
        .enc_comm_err2_i(enc[1]), .enc_count_err_i(enc[2]), .ctrl_uv_i(ind[1]),
        .autotune_fail_i(ind[2]), .power_module_fault_i(pmf), .alarm_out_o, .trip_active_o,
        .display_code_o, .abs_pos_valid_o);
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    task automatic chk(input logic [32:0] seen, input logic [32:0] want);
        n_compared++;
        if (seen !== want) begin
            err_count++;
            $display("FAIL %0t seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [32:0] want);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        exp_q.push_back({w, want});
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic pulse(input int n, input logic rst);
        if (rst) trip_reset_in_i <= 1'b1;
        else encoder_clear_in_i <= 1'b1;
        repeat (n) @(posedge clk_i);
        trip_reset_in_i <= 1'b0;
        encoder_clear_in_i <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatched %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk_i) begin
        if (pready_o === 1'b1) begin
            logic [33:0] e;
            e = exp_q.pop_front();
            chk({pslverr_o, e[33] ? 32'h0000_0000 : prdata_o}, e[32:0]);
        end
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        give_verdict();
    end
    initial begin
        repeat (10) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        apb(0, 12'h004, 0, 33'h0_0001_0000);
        apb(0, 12'h028, 0, 33'h0_0000_4100);
        apb(1, 12'h030, 0, 33'h1_0000_0000);
        apb(1, 12'h028, 0, 33'h1_0000_0000);
        $display("register test done");
        for (int k = 0; k < 3; k++) begin
            ind <= 3'(1 << k);
            repeat (3) @(posedge clk_i);
            chk(33'({alarm_out_o, trip_active_o, display_code_o}),
                33'(dc[k]));
        end
        ind <= '0;
        pulse(4, 1);
        $display("indication test done");
        for (int i = 0; i < 8; i++) begin
            flt <= 8'(1 << i);
            repeat (2) @(posedge clk_i);
            flt <= '0;
            repeat (3) @(posedge clk_i);
            chk(33'({alarm_out_o, abs_pos_valid_o, trip_active_o, display_code_o}),
                33'({i != 0, i != 5, 1'b1, codes[i]}));
            apb(0, 12'h028, 0, 33'h0_0000_4200 | 33'(codes[i]));
            if (i > 4) begin
                pulse(14, 0);
                pulse(14, 0);
                pulse(4, 1);
                apb(0, 12'h028, 0, 33'h0_0000_4200 | 33'(codes[i]));
                pulse(30, 0);
            end
            pulse(4, 1);
            apb(0, 12'h028, 0, 33'h0_0000_4100);
            $display("fault test %0d done", i);
        end
        rng = xs(rng);
        pos_cmd_i <= rng & 32'h0FFF_FFFF;
        pos_det_i <= (rng & 32'h0FFF_FFFF) + 32'h0001_0000;
        spd <= 16'(rng[11:0]);
        apb(0, 12'h028, 0, 33'h0_0000_4100);
        pos_det_i <= (rng & 32'h0FFF_FFFF) + 32'h0001_0001;
        apb(0, 12'h028, 0, 33'h0_0000_4253);
        pos_det_i <= rng & 32'h0FFF_FFFF;
        pulse(4, 1);
        apb(1, 12'h020, 32'h0000_0020, 33'h0_0000_0000);
        apb(1, 12'h000, 32'h0000_0013, 33'h0_0000_0000);
        quiet <= 1'b1;
        repeat (60) @(posedge clk_i);
        apb(0, 12'h028, 0, 33'h0_0000_423C);
        quiet <= 1'b0;
        repeat (20) @(posedge clk_i);
        pulse(4, 1);
        nest_depth_i <= 4'h9;
        repeat (3) @(posedge clk_i);
        chk(33'(alarm_out_o), 33'h0_0000_0001);
        apb(0, 12'h028, 0, 33'h0_0000_422C);
        nest_depth_i <= 4'h0;
        pulse(4, 1);
        pmf <= 1'b1;
        repeat (3) @(posedge clk_i);
        pmf <= 1'b0;
        pulse(4, 1);
        apb(0, 12'h028, 0, 33'h0_0000_441F);
        apb(1, 12'h000, 32'h0000_0033, 33'h0_0000_0000);
        pulse(4, 1);
        apb(0, 12'h028, 0, 33'h0_0000_6100);
        flt <= 8'h02;
        @(posedge clk_i);
        flt <= '0;
        repeat (3) @(posedge clk_i);
        chk(33'({alarm_out_o, display_code_o}), 33'h0_0000_010E);
        $display("sequence tests done");
        give_verdict();
    end
endmodule // stm_trip_monitor_bench
